/* File: core/htc_pkg.sv */
/*
 * constants and types for the host timer and counter register block.
 * assumes a 125 MHz core clock and a 16-bit sram-like host bus sampled on it.
 */
// Function
// - writing one to the run enable starts the timer; clearing it halts it.
// - a one-to-zero change of run enable forces the preload field to FFFFh.
// - the preload is the timer start value; it resets to FFFFh.
// - the timer raises periodic interrupt events at the configured interval.
// - a read-only field shows the live timer count; FFFFh after reset.
// - word order not all ones: A1 set reaches upper half, clear reaches lower.
// - word order all ones: mapping reversed, A1 set reaches lower half.
// - network transmit and receive move the lower halfword first, always.
// - free-running 32-bit counter starts at zero, counts 25 MHz cycles, wraps.
// - first halfword read captures the whole free-running count.
// - after reset the free-running counter reaches zero within 160 ns.
// - the free-running counter runs in every power state.
// - the dropped-frame counter increments on each discarded receive frame.
// - reading the dropped-frame counter returns it then clears it; zero at reset.
// - an event is raised when the dropped-frame count passes 7FFFFFFFh.
package htc_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0]  OFS_TIMER_CONFIG          = 8'h8C;
    localparam logic [7:0]  OFS_TIMER_CURRENT_COUNT   = 8'h90;
    localparam logic [7:0]  OFS_HOST_WORD_ORDER       = 8'h98;
    localparam logic [7:0]  OFS_CONTINUOUS_TICK_COUNT = 8'h9C;
    localparam logic [7:0]  OFS_DISCARDED_FRAME_COUNT = 8'hA0;

    // ==========================================================
    // fields and reset values
    localparam int          TIMER_EN_POS              = 29;
    localparam int          TIMER_EN_HALF_POS         = TIMER_EN_POS - 16;
    localparam logic [15:0] TIMER_PRELOAD_RST         = 16'hFFFF;
    localparam logic [15:0] TIMER_COUNT_RST           = 16'hFFFF;
    localparam logic [31:0] WORD_ORDER_RST            = 32'h00000000;
    localparam logic [31:0] WORD_ORDER_SWAP           = 32'hFFFFFFFF;
    localparam logic [31:0] TICK_COUNT_RST            = 32'h00000000;
    localparam logic [31:0] DROP_COUNT_RST            = 32'h00000000;
    localparam logic [31:0] DROP_COUNT_MID            = 32'h7FFFFFFF;

    // ==========================================================
    // timing
    localparam int          CLK_PERIOD_NS             = 8;
    localparam int          TICK_PERIOD_NS            = 40;
    localparam int          TICK_CYCLES               = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          TICK_CLEAR_NS             = 160;
    localparam int          TICK_CLEAR_CYCLES         = TICK_CLEAR_NS / CLK_PERIOD_NS;

    // ==========================================================
    // network halfword sequencer states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_LOW  = 2'b01,
        TX_HIGH = 2'b10
    } htc_tx_state_t;

endpackage

/* File: core/htc_half_sel.sv */
/*
 * halfword lane selector: decides whether a host access reaches the upper half.
 * assumes the word order register value and host address bit 1 are stable inputs.
 */
`timescale 1ns/10ps
module htc_half_sel (
    input  wire logic [31:0] word_order_i,
    input  wire logic        addr_a1_i,
    output logic             upper_o
);
    import htc_pkg::*;

    // only the exact all-ones pattern swaps; any other value keeps natural order
    always_comb begin
        if (word_order_i == WORD_ORDER_SWAP) begin
            upper_o = ~addr_a1_i;
        end else begin
            upper_o = addr_a1_i;
        end
    end

endmodule

/* File: core/htc_tick_counter.sv */
/*
 * free-running 32-bit counter advanced once per 25 MHz period.
 * assumes a 125 MHz clock; the 25 MHz period is made by a prescaler, no second clock.
 */
`timescale 1ns/10ps
module htc_tick_counter (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    output logic             tick_o,
    output logic [31:0]      count_o
);
    import htc_pkg::*;

    localparam logic [2:0] PRESCALE_LAST = 3'(TICK_CYCLES - 1);

    logic [2:0]  pre_q;
    logic [31:0] count_q;

    // ==========================================================
    // prescaler
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q <= 3'h0;
        end else if (pre_q == PRESCALE_LAST) begin
            pre_q <= 3'h0;
        end else begin
            pre_q <= pre_q + 3'h1;
        end
    end

    assign tick_o = (pre_q == PRESCALE_LAST);

    // ==========================================================
    // counter: no power-state gating by design, it must never stop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= TICK_COUNT_RST;
        end else if (tick_o) begin
            count_q <= count_q + 32'h1;
        end
    end

    assign count_o = count_q;

endmodule

/* File: core/htc_regs.sv */
/*
 * host timer and counter register block: general purpose timer, free-running
 * counter, dropped-frame counter, word order control and network halfword order.
 * assumes host bus strobes are synchronous to clk_i and each strobe lasts at
 * least one cycle; the testbench resolves the data bus from data_oe_o.
 */
`timescale 1ns/10ps
module htc_regs (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // host bus
    input  wire logic        cs_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic [7:1]  addr_i,
    input  wire logic [15:0] data_i,
    output logic      [15:0] data_o,
    output logic             data_oe_o,
    // events
    input  wire logic        frame_drop_i,
    output logic             timer_event_o,
    output logic             drop_half_event_o,
    // network transmit path
    input  wire logic [31:0] tx_word_i,
    input  wire logic        tx_word_valid_i,
    output logic             tx_word_ready_o,
    output logic      [15:0] net_tx_half_o,
    output logic             net_tx_valid_o,
    input  wire logic        net_tx_ready_i,
    // network receive path
    input  wire logic [15:0] net_rx_half_i,
    input  wire logic        net_rx_valid_i,
    output logic      [31:0] rx_word_o,
    output logic             rx_word_valid_o
);
    import htc_pkg::*;

    // ==========================================================
    // declarations
    logic          rd_act_q;
    logic          wr_act_q;
    logic          rd_start;
    logic          wr_start;
    logic [7:0]    byte_addr;
    logic          upper;
    logic          hit_cfg;
    logic          hit_cnt;
    logic          hit_ord;
    logic          hit_tick;
    logic          hit_drop;
    logic [31:0]   rd_word;
    logic          timer_en_q;
    logic          timer_en_prev_q;
    logic [15:0]   preload_q;
    logic [15:0]   timer_count_q;
    logic          timer_event_q;
    logic [31:0]   word_order_q;
    logic          tick;
    logic [31:0]   tick_count_value;
    logic [31:0]   tick_hold_q;
    logic          tick_pend_q;
    logic [31:0]   drop_q;
    logic [31:0]   drop_hold_q;
    logic          drop_pend_q;
    logic          drop_clr;
    logic          drop_half_q;
    htc_tx_state_t tx_state_q;
    logic [31:0]   tx_word_q;
    logic          rx_have_low_q;
    logic [15:0]   rx_low_q;
    logic [31:0]   rx_word_q;
    logic          rx_valid_q;

    // ==========================================================
    // host strobes: one pulse per access at the strobe's leading edge
    assign rd_start  = ~cs_n_i & ~rd_n_i & ~rd_act_q;
    assign wr_start  = ~cs_n_i & ~wr_n_i & ~wr_act_q;
    assign byte_addr = {addr_i[7:2], 2'b00};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
        end else begin
            rd_act_q <= ~cs_n_i & ~rd_n_i;
            wr_act_q <= ~cs_n_i & ~wr_n_i;
        end
    end

    // ==========================================================
    // address decode and lane select
    always_comb begin
        hit_cfg  = 1'b0;
        hit_cnt  = 1'b0;
        hit_ord  = 1'b0;
        hit_tick = 1'b0;
        hit_drop = 1'b0;
        if (byte_addr == OFS_TIMER_CONFIG) begin
            hit_cfg = 1'b1;
        end else if (byte_addr == OFS_TIMER_CURRENT_COUNT) begin
            hit_cnt = 1'b1;
        end else if (byte_addr == OFS_HOST_WORD_ORDER) begin
            hit_ord = 1'b1;
        end else if (byte_addr == OFS_CONTINUOUS_TICK_COUNT) begin
            hit_tick = 1'b1;
        end else if (byte_addr == OFS_DISCARDED_FRAME_COUNT) begin
            hit_drop = 1'b1;
        end
    end

    htc_half_sel u_half_sel (
        .word_order_i (word_order_q),
        .addr_a1_i    (addr_i[1]),
        .upper_o      (upper)
    );

    // ==========================================================
    // read data: unmapped offsets and reserved bits read as zero
    always_comb begin
        rd_word = 32'h0;
        if (hit_cfg) begin
            rd_word = {2'b00, timer_en_q, 13'h0, preload_q};
        end else if (hit_cnt) begin
            rd_word = {16'h0, timer_count_q};
        end else if (hit_ord) begin
            rd_word = word_order_q;
        end else if (hit_tick) begin
            rd_word = tick_pend_q ? tick_hold_q : tick_count_value;
        end else if (hit_drop) begin
            rd_word = drop_pend_q ? drop_hold_q : drop_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_o <= 16'h0;
        end else if (rd_start) begin
            data_o <= upper ? rd_word[31:16] : rd_word[15:0];
        end
    end

    assign data_oe_o = rd_act_q;

    // ==========================================================
    // word order register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_order_q <= WORD_ORDER_RST;
        end else if (wr_start && hit_ord && upper) begin
            word_order_q[31:16] <= data_i;
        end else if (wr_start && hit_ord) begin
            word_order_q[15:0] <= data_i;
        end
    end

    // ==========================================================
    // timer configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_en_q <= 1'b0;
        end else if (wr_start && hit_cfg && upper) begin
            timer_en_q <= data_i[TIMER_EN_HALF_POS];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            preload_q <= TIMER_PRELOAD_RST;
        end else if (timer_en_prev_q && !timer_en_q) begin
            preload_q <= TIMER_PRELOAD_RST;
        end else if (wr_start && hit_cfg && !upper) begin
            preload_q <= data_i;
        end
    end

    // ==========================================================
    // timer count: loads on start, counts down on the 25 MHz tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_en_prev_q <= 1'b0;
        end else begin
            timer_en_prev_q <= timer_en_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_count_q <= TIMER_COUNT_RST;
            timer_event_q <= 1'b0;
        end else begin
            timer_event_q <= 1'b0;
            if (timer_en_q && !timer_en_prev_q) begin
                timer_count_q <= preload_q;
            end else if (timer_en_q && tick) begin
                if (timer_count_q == 16'h0) begin
                    timer_count_q <= preload_q;
                    timer_event_q <= 1'b1;
                end else begin
                    timer_count_q <= timer_count_q - 16'h1;
                end
            end
        end
    end

    assign timer_event_o = timer_event_q;

    // ==========================================================
    // free-running counter with coherent two-halfword read
    htc_tick_counter u_tick (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_o  (tick),
        .count_o (tick_count_value)
    );

    // a read of either half captures all 32 bits; the next read drains the capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_hold_q <= 32'h0;
            tick_pend_q <= 1'b0;
        end else if (rd_start && hit_tick && !tick_pend_q) begin
            tick_hold_q <= tick_count_value;
            tick_pend_q <= 1'b1;
        end else if (rd_start && hit_tick) begin
            tick_pend_q <= 1'b0;
        end
    end

    // ==========================================================
    // dropped-frame counter, cleared by the first halfword read
    assign drop_clr = rd_start && hit_drop && !drop_pend_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drop_hold_q <= 32'h0;
            drop_pend_q <= 1'b0;
        end else if (drop_clr) begin
            drop_hold_q <= drop_q;
            drop_pend_q <= 1'b1;
        end else if (rd_start && hit_drop) begin
            drop_pend_q <= 1'b0;
        end
    end

    // a drop in the clearing cycle is kept as the first count of the new tally
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drop_q <= DROP_COUNT_RST;
        end else if (drop_clr) begin
            drop_q <= {31'h0, frame_drop_i};
        end else if (frame_drop_i) begin
            drop_q <= drop_q + 32'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drop_half_q <= 1'b0;
        end else begin
            drop_half_q <= frame_drop_i && !drop_clr && (drop_q == DROP_COUNT_MID);
        end
    end

    assign drop_half_event_o = drop_half_q;

    // ==========================================================
    // network transmit: lower halfword always leaves first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_state_q <= TX_IDLE;
            tx_word_q  <= 32'h0;
        end else begin
            case (tx_state_q)
                TX_IDLE: begin
                    if (tx_word_valid_i) begin
                        tx_word_q  <= tx_word_i;
                        tx_state_q <= TX_LOW;
                    end
                end
                TX_LOW: begin
                    if (net_tx_ready_i) begin
                        tx_state_q <= TX_HIGH;
                    end
                end
                TX_HIGH: begin
                    if (net_tx_ready_i) begin
                        tx_state_q <= TX_IDLE;
                    end
                end
                default: begin
                    tx_state_q <= TX_IDLE;
                end
            endcase
        end
    end

    assign tx_word_ready_o = (tx_state_q == TX_IDLE);
    assign net_tx_valid_o  = (tx_state_q == TX_LOW) || (tx_state_q == TX_HIGH);
    assign net_tx_half_o   = (tx_state_q == TX_HIGH) ? tx_word_q[31:16] : tx_word_q[15:0];

    // ==========================================================
    // network receive: first halfword of a pair is the lower one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_have_low_q <= 1'b0;
            rx_low_q      <= 16'h0;
            rx_word_q     <= 32'h0;
            rx_valid_q    <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            if (net_rx_valid_i && !rx_have_low_q) begin
                rx_low_q      <= net_rx_half_i;
                rx_have_low_q <= 1'b1;
            end else if (net_rx_valid_i) begin
                rx_word_q     <= {net_rx_half_i, rx_low_q};
                rx_valid_q    <= 1'b1;
                rx_have_low_q <= 1'b0;
            end
        end
    end

    assign rx_word_o       = rx_word_q;
    assign rx_word_valid_o = rx_valid_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_halt_reloads_preload: assert property ($fell(timer_en_q) |=> preload_q == TIMER_PRELOAD_RST)
        else $error("preload not forced to all ones after halt");
    a_start_loads_count: assert property ($rose(timer_en_q) |=> timer_count_q == $past(preload_q))
        else $error("timer did not load preload on start");
    a_halted_count_holds: assert property (!timer_en_q && !$rose(timer_en_q) |=> $stable(timer_count_q))
        else $error("halted timer count changed");
    a_timer_wrap_event: assert property (timer_en_q && timer_en_prev_q && tick && timer_count_q == 16'h0 |=> timer_event_o && timer_count_q == $past(preload_q))
        else $error("timer wrap did not reload and signal");
    a_event_only_on_wrap: assert property (timer_event_o |-> $past(timer_count_q) == 16'h0)
        else $error("timer event without wrap");
    a_lane_select: assert property (rd_start && hit_cnt && word_order_q != WORD_ORDER_SWAP |=> data_o == ($past(addr_i[1]) ? 16'h0 : $past(timer_count_q)))
        else $error("natural lane mapping wrong");
    a_lane_swapped: assert property (rd_start && hit_cfg && word_order_q == WORD_ORDER_SWAP && !addr_i[1] |=> data_o == {2'b00, $past(timer_en_q), 13'h0})
        else $error("swapped lane mapping wrong");
    a_tick_spacing: assert property (tick |=> !tick [*4] ##1 tick)
        else $error("free-running counter not at 25 MHz");
    a_tick_coherent: assert property (rd_start && hit_tick && !tick_pend_q |=> tick_hold_q == $past(tick_count_value) && tick_pend_q)
        else $error("free-running count not captured on first read");
    a_drop_clear: assert property (drop_clr && !frame_drop_i |=> drop_q == 32'h0 && drop_hold_q == $past(drop_q))
        else $error("dropped-frame counter not cleared by read");
    a_drop_count: assert property (frame_drop_i && !drop_clr |=> drop_q == $past(drop_q) + 32'h1)
        else $error("dropped-frame counter missed an increment");
    a_drop_midpoint: assert property (drop_half_event_o |-> drop_q == 32'h80000000)
        else $error("midpoint event at wrong count");
    a_tx_low_first: assert property (tx_state_q == TX_IDLE && tx_word_valid_i |=> net_tx_valid_o && net_tx_half_o == $past(tx_word_i[15:0]))
        else $error("transmit did not start with lower halfword");
    a_tick_after_reset: assert property (disable iff (1'b0) $fell(rst_i) |-> tick_count_value == 32'h0)
        else $error("free-running counter not zero after reset");

    c_timer_wrap: cover property (timer_event_o);
    c_drop_midpoint: cover property (drop_half_event_o);
    c_tick_two_reads: cover property (rd_start && hit_tick ##[1:40] rd_start && hit_tick);
    c_swapped_read: cover property (rd_start && word_order_q == WORD_ORDER_SWAP);

endmodule

/* File: verification/htc_host_model.sv */
/*
 * host cpu model for the sram-like 16-bit bus of the register block.
 * assumes it is called from the bench; drives its outputs at the falling edge.
 */
`timescale 1ns/10ps
module htc_host_model (
    input  wire logic        clk_i,
    output logic             cs_n_o,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic [7:1]       addr_o,
    output logic [15:0]      data_o,
    input  wire logic [15:0] data_i,
    input  wire logic        data_oe_i,
    output logic [15:0]      rdata_o,
    output logic             rvalid_o
);
    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        addr_o = 7'h00;
        data_o = 16'h0000;
        rdata_o = 16'h0000;
        rvalid_o = 1'b0;
    end

    // ==========================================================
    // bus cycles; a gap after each access so every start is a fresh edge
    task automatic hwr(input logic [7:0] ofs, input logic a1, input logic [15:0] d);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        wr_n_o = 1'b0;
        addr_o = {ofs[7:2], a1};
        data_o = d;
        @(negedge clk_i);
        cs_n_o = 1'b1;
        wr_n_o = 1'b1;
        data_o = ~d; // released bus never shows the old value
        @(negedge clk_i);
    endtask

    task automatic hrd(input logic [7:0] ofs, input logic a1);
        int n;
        n = 0;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        addr_o = {ofs[7:2], a1};
        do begin
            @(negedge clk_i);
            n++;
        end while (data_oe_i !== 1'b1 && n < 8);
        rdata_o = data_i;
        rvalid_o = 1'b1;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        @(negedge clk_i);
        rvalid_o = 1'b0;
        @(negedge clk_i);
    endtask
endmodule

/* File: verification/htc_regs_tb_top.sv */
/*
 * self-checking bench for the register block: host reads, timer, counters, lanes.
 * assumes the host model drives the bus; expectations are queued by the drivers.
 */
`timescale 1ns/10ps
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %0t %s got %h exp %h", $time, m, g, e); end end
module htc_regs_tb_top;
    import htc_pkg::*;
    logic        clk, rst, cs_n, rd_n, wr_n, oe, hval, drop, tev, txv, txr, ntv, ntr, nrv, rxv;
    logic        nochk, dhe;
    logic [7:1]  addr;
    logic [15:0] wdata, rdata, hdata, half_tx, half_rx, e16, p, x;
    logic [31:0] tx_word, rx_word, rx, e32;
    int          err_total, total_checks, cyc, tev_n, dh_n, n, k;
    logic [15:0] hq[$], nq[$];
    logic [31:0] rq[$];

    htc_regs dut (.clk_i(clk), .rst_i(rst), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .addr_i(addr), .data_i(wdata), .data_o(rdata), .data_oe_o(oe),
        .frame_drop_i(drop), .timer_event_o(tev), .drop_half_event_o(dhe),
        .tx_word_i(tx_word), .tx_word_valid_i(txv), .tx_word_ready_o(txr),
        .net_tx_half_o(half_tx), .net_tx_valid_o(ntv), .net_tx_ready_i(ntr),
        .net_rx_half_i(half_rx), .net_rx_valid_i(nrv), .rx_word_o(rx_word),
        .rx_word_valid_o(rxv));
    htc_host_model host (.clk_i(clk), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .addr_o(addr), .data_o(wdata), .data_i(rdata), .data_oe_i(oe), .rdata_o(hdata),
        .rvalid_o(hval));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================================
    // result watcher; values seen at the edge are the pre-edge outputs
    always @(posedge clk) begin
        cyc++;
        if (tev === 1'b1) tev_n++;
        if (dhe === 1'b1) dh_n++;
        if (hval === 1'b1 && !nochk) begin
            e16 = hq.size() > 0 ? hq.pop_front() : 16'hXXXX;
            `CHK(hdata, e16, "host read")
        end
        if (ntv === 1'b1 && ntr === 1'b1) begin
            e16 = nq.size() > 0 ? nq.pop_front() : 16'hXXXX;
            `CHK(half_tx, e16, "tx half")
        end
        if (rxv === 1'b1) begin
            e32 = rq.size() > 0 ? rq.pop_front() : 32'hXXXXXXXX;
            `CHK(rx_word, e32, "rx word")
        end
        // limit last so nothing runs after the closing report
        if (cyc > 20000) begin
            err_total++;
            test_done();
        end
    end
    always @(negedge clk) ntr <= 1'($urandom_range(1, 0));

    task automatic rdq(input logic [7:0] ofs, input logic a1, input logic [15:0] e);
        hq.push_back(e);
        host.hrd(ofs, a1);
    endtask

    task automatic wait_ev(output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (tev !== 1'b1 && c < 400);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        {err_total, total_checks, cyc, tev_n, dh_n} = '0;
        {rst, drop, txv, nrv, nochk} = 5'b10000;
        {tx_word, half_rx} = '0;
        n = $urandom(32'hF937);
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (TICK_CLEAR_CYCLES) @(negedge clk);
        rdq(OFS_TIMER_CONFIG, 1'b0, TIMER_PRELOAD_RST);
        rdq(OFS_TIMER_CONFIG, 1'b1, 16'h0000);
        rdq(OFS_TIMER_CURRENT_COUNT, 1'b0, TIMER_COUNT_RST);
        rdq(OFS_HOST_WORD_ORDER, 1'b0, 16'h0000);
        rdq(OFS_DISCARDED_FRAME_COUNT, 1'b0, 16'h0000);
        rdq(OFS_DISCARDED_FRAME_COUNT, 1'b1, 16'h0000);
        $display("test reset values done");
        p = 16'($urandom_range(9, 2));
        host.hwr(OFS_TIMER_CONFIG, 1'b0, p);
        rdq(OFS_TIMER_CONFIG, 1'b0, p);
        host.hwr(OFS_TIMER_CONFIG, 1'b1, 16'h2000);
        wait_ev(k);
        wait_ev(k);
        `CHK(k, (int'(p) + 1) * TICK_CYCLES, "timer period")
        host.hwr(OFS_TIMER_CONFIG, 1'b1, 16'h0000);
        rdq(OFS_TIMER_CONFIG, 1'b0, 16'hFFFF);
        k = tev_n;
        repeat (100) @(negedge clk);
        `CHK(tev_n, k, "timer halted")
        $display("test timer done");
        host.hwr(OFS_HOST_WORD_ORDER, 1'b1, 16'hFFFF);
        rdq(OFS_TIMER_CONFIG, 1'b0, 16'hFFFF);
        host.hwr(OFS_HOST_WORD_ORDER, 1'b0, 16'hFFFF);
        rdq(OFS_TIMER_CONFIG, 1'b1, 16'hFFFF);
        rdq(OFS_TIMER_CONFIG, 1'b0, 16'h0000);
        host.hwr(OFS_HOST_WORD_ORDER, 1'b0, 16'h0000);
        rdq(OFS_HOST_WORD_ORDER, 1'b1, 16'h0000);
        rdq(OFS_HOST_WORD_ORDER, 1'b0, 16'hFFFF);
        $display("test word order done");
        // counter reads of the upper half stay zero for this short run
        nochk = 1'b1;
        host.hrd(OFS_CONTINUOUS_TICK_COUNT, 1'b0);
        x = hdata;
        nochk = 1'b0;
        repeat (100) @(negedge clk);
        rdq(OFS_CONTINUOUS_TICK_COUNT, 1'b0, x);
        rdq(OFS_CONTINUOUS_TICK_COUNT, 1'b1, 16'h0000);
        nochk = 1'b1;
        host.hrd(OFS_CONTINUOUS_TICK_COUNT, 1'b0);
        nochk = 1'b0;
        `CHK(hdata - x inside {[16'd20 : 16'd30]}, 1'b1, "tick rate")
        $display("test tick counter done");
        k = $urandom_range(20, 1);
        repeat (k) begin
            @(negedge clk);
            drop = 1'b1;
            @(negedge clk);
            drop = 1'b0;
            repeat ($urandom_range(3, 0)) @(negedge clk);
        end
        rdq(OFS_DISCARDED_FRAME_COUNT, 1'b0, 16'(k));
        rdq(OFS_DISCARDED_FRAME_COUNT, 1'b1, 16'h0000);
        rdq(OFS_DISCARDED_FRAME_COUNT, 1'b0, 16'h0000);
        rdq(OFS_DISCARDED_FRAME_COUNT, 1'b1, 16'h0000);
        $display("test drop counter done");
        repeat (4) begin
            @(negedge clk);
            while (txr !== 1'b1) @(negedge clk);
            tx_word = $urandom;
            nq.push_back(tx_word[15:0]);
            nq.push_back(tx_word[31:16]);
            txv = 1'b1;
            @(negedge clk);
            txv = 1'b0;
        end
        repeat (4) begin
            rx = $urandom;
            rq.push_back(rx);
            @(negedge clk);
            nrv = 1'b1;
            half_rx = rx[15:0];
            @(negedge clk);
            half_rx = rx[31:16];
            @(negedge clk);
            nrv = 1'b0;
            half_rx = ~rx[31:16];
        end
        repeat (40) @(negedge clk);
        `CHK(nq.size() + rq.size(), 0, "unmatched network data")
        `CHK(dh_n, 0, "midpoint event without crossing")
        $display("test network order done");
        test_done();
    end
endmodule
